// *** tb_top.sv ***
// bench joining core and device ends through the interface
// assumes low speed mode with a low clock tick every second cycle
`timescale 1ns/1ps
`include "wdt_trap_cfg.svh"
module tb_top;
   logic core_clk, rst, req_wr, req_fetch, req_imf, req_low_speed, req_tap_sel, req_low_tick;
   logic [15:0] req_addr;
   logic [7:0] req_data;
   logic nmi_wdt, nmi_trap, chip_reset_n;
   int n_errors, n_checks, n_wdt, n_trap, n_low, cyc, w0, t0, l0;
   wdt_trap_if wdt_trap_if_i ();
   wdt_trap_dev wdt_trap_dev_i (.core_clk(core_clk), .rst(rst), .bus(wdt_trap_if_i));
   wdt_trap_core wdt_trap_core_i (.core_clk(core_clk), .rst(rst), .req_wr(req_wr),
      .req_addr(req_addr), .req_data(req_data), .req_fetch(req_fetch), .req_imf(req_imf),
      .req_low_speed(req_low_speed), .req_tap_sel(req_tap_sel), .req_low_tick(req_low_tick),
      .nmi_wdt(nmi_wdt), .nmi_trap(nmi_trap), .chip_reset_n(chip_reset_n), .bus(wdt_trap_if_i));
   wdt_trap_assertions wdt_trap_assertions_i (.core_clk(core_clk), .rst(rst),
      .wr_en(wdt_trap_if_i.wr_en), .wr_addr(wdt_trap_if_i.wr_addr),
      .wr_data(wdt_trap_if_i.wr_data), .fetch_en(wdt_trap_if_i.fetch_en),
      .fetch_addr(wdt_trap_if_i.fetch_addr), .wdt_irq(wdt_trap_if_i.wdt_irq),
      .trap_irq(wdt_trap_if_i.trap_irq), .reset_n(wdt_trap_if_i.reset_n));
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   // counted off the edge so the main sequence never races them
   always @(negedge core_clk) begin
      cyc++;
      if (nmi_wdt === 1'b1) n_wdt++;
      if (nmi_trap === 1'b1) n_trap++;
      if (chip_reset_n === 1'b0) n_low++;
      if (cyc > 40000) begin
         n_errors++;
         final_report();
      end
   end
   always @(posedge core_clk) req_low_tick <= ~req_low_tick;
   task automatic chk(input int seen, input int exp);
      n_checks++;
      if (seen != exp) begin
         n_errors++;
         $display("Error at %0t: saw %0d expected %0d", $time, seen, exp);
      end
   endtask
   task automatic req(input logic f, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req_wr <= !f;
      req_fetch <= f;
      req_addr <= a;
      req_data <= d;
      @(posedge core_clk);
      req_wr <= 1'b0;
      req_fetch <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic done(input string nm, input int ew, input int et, input int el);
      chk(n_wdt - w0, ew);
      chk(n_trap - t0, et);
      chk(n_low - l0, el);
      $display("test %s done", nm);
      w0 = n_wdt;
      t0 = n_trap;
      l0 = n_low;
   endtask
   task automatic hard_reset;
      rst <= 1'b1;
      idle(5);
      rst <= 1'b0;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {rst, req_wr, req_fetch, req_low_tick, req_addr, req_data} = '0;
      {req_imf, req_low_speed, req_tap_sel} = 3'b111;
      hard_reset();
      req(1, 16'h0010, 8'h00);
      idle(40);
      done("sfr fetch after reset", 0, 0, 24);
      req(0, `CFG_ADDR, 8'h0e);
      req(0, `CMD_ADDR, `CODE_CLEAR);
      req_imf <= 1'b0;
      req(1, 16'h0100, 8'h00);
      req(0, `CMD_ADDR, `CODE_COMMIT);
      req(1, 16'h0100, 8'h00);
      req(1, 16'h0020, 8'h00);
      req(1, `SFR_HI, 8'h00);
      idle(10);
      done("fetch traps", 0, 3, 0);
      req(0, `CFG_ADDR, 8'h0f);
      req(0, `CMD_ADDR, `CODE_CLEAR);
      idle(2000);
      req(0, `CMD_ADDR, 8'h55);
      idle(2300);
      done("overflow irq", 1, 0, 0);
      repeat (4) begin
         req(0, `CMD_ADDR, `CODE_CLEAR);
         idle(2500);
      end
      done("periodic clear", 0, 0, 0);
      req(0, `CMD_ADDR, `CODE_CLEAR);
      req(0, `CMD_ADDR, `CODE_DISABLE);
      idle(4300);
      done("disable refused", 1, 0, 0);
      req(0, `CMD_ADDR, `CODE_CLEAR);
      req(0, `CFG_ADDR, 8'h06);
      req(0, `CMD_ADDR, `CODE_DISABLE);
      idle(9000);
      done("disabled", 0, 0, 0);
      hard_reset();
      req(0, `CFG_ADDR, 8'h3f);
      req(0, `CMD_ADDR, `CODE_CLEAR);
      idle(4300);
      done("overflow reset", 0, 0, 24);
      final_report();
   end
endmodule

// *** wdt_trap_assertions.sv ***
// checker for the bus between core and watchdog
// assumes tb_top wires the interface signals to it by name
`timescale 1ns/1ps
`include "wdt_trap_cfg.svh"
module wdt_trap_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // bus
   input wire logic wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic fetch_en,
   input wire logic [15:0] fetch_addr,
   input wire logic wdt_irq,
   input wire logic trap_irq,
   input wire logic reset_n
);
   logic [7:0] cfg_q;
   logic ram_q;
   logic en_q;
   logic [5:0] low_q;
   wire cfg_w = wr_en && wr_addr == `CFG_ADDR;
   wire cmd_w = wr_en && wr_addr == `CMD_ADDR;
   wire special_register_area = fetch_en && fetch_addr <= `SFR_HI;
   wire ram = fetch_en && fetch_addr >= `RAM_LO && fetch_addr <= `RAM_HI;
   // shadow config; a chip reset restores it too
   always_ff @(posedge core_clk) begin
      low_q <= reset_n ? 6'h00 : low_q + 6'h01;
      if (rst || !reset_n) begin
         cfg_q <= `CFG_RESET;
         ram_q <= 1'b1;
         en_q <= 1'b1;
      end else begin
         if (cfg_w) begin
            cfg_q <= {wr_data[7:1], wr_data[0] & cfg_q[0]};
            en_q <= en_q | wr_data[`BIT_EN];
         end
         if (cmd_w && wr_data == `CODE_COMMIT) ram_q <= cfg_q[`BIT_ATRAM];
         if (cmd_w && wr_data == `CODE_DISABLE && !cfg_q[`BIT_EN]) en_q <= 1'b0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sfr_irq_a:
      assert property (special_register_area && reset_n && !cfg_q[`BIT_ATACT] |=> trap_irq) else $error("no trap irq");
   sfr_rst_a:
      assert property (special_register_area && reset_n && cfg_q[`BIT_ATACT] |=> !reset_n) else $error("no trap reset");
   ram_gate_a:
      assert property (ram && !ram_q |=> !trap_irq) else $error("ram trap not gated");
   ram_trap_a:
      assert property (ram && ram_q && reset_n && !cfg_q[`BIT_ATACT] |=> trap_irq)
         else $error("ram fetch gave no trap irq");
   rst_len_a:
      assert property (low_q <= 6'd24) else $error("reset held too long");
   wdt_act_a:
      assert property (wdt_irq |-> !cfg_q[`BIT_ACT]) else $error("irq under reset action");
   wdt_off_a:
      assert property (!en_q |=> !wdt_irq) else $error("irq while disabled");
   clear_quiet_a:
      assert property (cmd_w && wr_data == `CODE_CLEAR |-> ##2 (!wdt_irq)[*8])
         else $error("overflow right after clear");
endmodule

// *** wdt_trap_cfg.svh ***
// constants for the watchdog / fetch trap block
// assumes inclusion by both ends, the checker and the bench
`ifndef WDT_TRAP_CFG_SVH
`define WDT_TRAP_CFG_SVH
`define CFG_ADDR 16'h0034
`define CMD_ADDR 16'h0035
`define CODE_COMMIT 8'hd2
`define CODE_CLEAR 8'h4e
`define CODE_DISABLE 8'hb1
`define BIT_ATRAM 5
`define BIT_ATACT 4
`define BIT_EN 3
`define BIT_PER_HI 2
`define BIT_PER_LO 1
`define BIT_ACT 0
`define CFG_RESET 8'h39
`define RST_HOLD_NS 240
`define CLK_NS 10
`define RST_HOLD_CYC ((`RST_HOLD_NS) / (`CLK_NS))
`define SFR_LO 16'h0000
`define SFR_HI 16'h003f
`define RAM_LO 16'h0040
`define RAM_HI 16'h023f
`endif

// *** wdt_trap_core.sv ***
// core-side end: turns user requests into bus strobes
// assumes one request per cycle at most
`timescale 1ns/1ps
`include "wdt_trap_cfg.svh"
module wdt_trap_core (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // user side
   input wire logic req_wr,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic req_fetch,
   input wire logic req_imf,
   input wire logic req_low_speed,
   input wire logic req_tap_sel,
   input wire logic req_low_tick,
   output logic nmi_wdt,
   output logic nmi_trap,
   output logic chip_reset_n,
   // device side
   wdt_trap_if.core bus
);
   typedef struct packed {
      wdt_trap_pkg::core_state_type st;
      logic [15:0] addr;
      logic [7:0] data;
      logic interrupt_master_flag;
      logic low;
      logic tap;
      logic tick;
      logic nmi_wdt;
      logic nmi_trap;
      logic rst_n;
   } state_type;
   state_type s_q;
   state_type s_d;
   always_comb begin
      s_d = s_q;
      s_d.st = wdt_trap_pkg::ST_IDLE;
      // stack setup is software's duty before these strobes
      if (req_wr) begin
         s_d.st = wdt_trap_pkg::ST_WRITE;
      end else if (req_fetch) begin
         s_d.st = wdt_trap_pkg::ST_FETCH;
      end
      s_d.addr = req_addr;
      s_d.data = req_data;
      s_d.interrupt_master_flag = req_imf;
      s_d.low = req_low_speed;
      s_d.tap = req_tap_sel;
      s_d.tick = req_low_tick;
      s_d.nmi_wdt = bus.wdt_irq;
      s_d.nmi_trap = bus.trap_irq;
      s_d.rst_n = bus.reset_n;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.rst_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   // ram execution needs trap enable cleared and committed first
   assign bus.wr_en = (s_q.st == wdt_trap_pkg::ST_WRITE);
   assign bus.fetch_en = (s_q.st == wdt_trap_pkg::ST_FETCH);
   assign bus.wr_addr = s_q.addr;
   assign bus.fetch_addr = s_q.addr;
   assign bus.wr_data = s_q.data;
   assign bus.interrupt_master_flag = s_q.interrupt_master_flag;
   assign bus.low_speed = s_q.low;
   assign bus.tap_sel = s_q.tap;
   assign bus.low_clk_tick = s_q.tick;
   assign nmi_wdt = s_q.nmi_wdt;
   assign nmi_trap = s_q.nmi_trap;
   assign chip_reset_n = s_q.rst_n;
endmodule

// *** wdt_trap_dev.sv ***
// watchdog with instruction fetch trap, device end
// assumes core writes and fetches are single-cycle strobes on core_clk
//
// Contract
// - enable bit set at reset, counting when set
// - disable: clear imf, 4e, enable 0, b1
// - disable code accepted only while enable is 0
// - counters held cleared while disabled
// - period select picks overflow time per clock
// - clear code resets binary stage, prescaler runs
// - interrupt action cannot return to reset action
// - action 0 overflow raises watchdog interrupt
// - watchdog interrupt ignores interrupt master flag
// - new watchdog interrupt preempts, old stays pending
// - stack pointer set before choosing interrupt action
// - action 1 overflow drives reset pin low
// - watchdog reset lasts at most 24 high clocks
// - command codes d2, 4e, b1; others ignored
// - trap controls share config and command addresses
// - ram trap enable takes effect after d2
// - ram code needs trap enable cleared, committed
// - fetch from special area always traps
// - action 0 trap raises fetch trap interrupt
// - trap interrupt non-maskable, preempts, old pending
// - stack pointer set before any trap
// - action 1 trap drives reset pin low
// - trap reset lasts at most 24 high clocks
`timescale 1ns/1ps
`include "wdt_trap_cfg.svh"
module wdt_trap_dev #(
   parameter int PRE_W = 23
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // core side
   wdt_trap_if.dev bus
);
   localparam logic [4:0] HOLD = 5'(`RST_HOLD_CYC);
   typedef struct packed {
      logic [7:0] cfg;
      logic ram_trap;
      logic [PRE_W-1:0] pre;
      logic [1:0] bin;
      logic tap_prev;
      logic [4:0] hold;
      logic wdt_irq;
      logic trap_irq;
      logic reset_n;
   } state_type;
   state_type s_q;
   state_type s_d;
   logic enable;
   logic [4:0] tap;
   logic tap_bit;
   logic tick;
   logic cfg_wr;
   logic cmd_wr;
   logic sfr_fetch;
   logic ram_fetch;
   logic trap;
   logic ovf;
   always_comb begin
      enable = s_q.cfg[`BIT_EN];
      // period select to prescaler tap
      // low clock: 2^17..2^11 of low_clk_tick, tap 14 down to 8 (binary adds 2 bits)
      // high clock: 2^25..2^19, tap 22 down to 16
      if (bus.low_speed || bus.tap_sel) begin
         tap = 5'd14 - {2'b00, s_q.cfg[`BIT_PER_HI:`BIT_PER_LO], 1'b0};
      end else begin
         tap = 5'd22 - {2'b00, s_q.cfg[`BIT_PER_HI:`BIT_PER_LO], 1'b0};
      end
      tap_bit = s_q.pre[tap];
      tick = s_q.tap_prev && !tap_bit;
      cfg_wr = bus.wr_en && (bus.wr_addr == `CFG_ADDR);
      cmd_wr = bus.wr_en && (bus.wr_addr == `CMD_ADDR);
      sfr_fetch = bus.fetch_en && (bus.fetch_addr <= `SFR_HI);
      ram_fetch = bus.fetch_en && (bus.fetch_addr >= `RAM_LO)
         && (bus.fetch_addr <= `RAM_HI) && s_q.ram_trap;
      trap = sfr_fetch || ram_fetch;
      ovf = enable && tick && (s_q.bin == 2'b11);
      s_d = s_q;
      s_d.wdt_irq = 1'b0;
      s_d.trap_irq = 1'b0;
      // prescaler: high clock every cycle, low clock on its tick
      if (!enable) begin
         s_d.pre = '0;
         s_d.bin = 2'b00;
      end else begin
         if (!(bus.low_speed || bus.tap_sel) || bus.low_clk_tick) begin
            s_d.pre = s_q.pre + 1'b1;
         end
         if (tick) begin
            s_d.bin = s_q.bin + 2'b01;
         end
      end
      s_d.tap_prev = tap_bit;
      if (cfg_wr) begin
         s_d.cfg[`BIT_ATRAM] = bus.wr_data[`BIT_ATRAM];
         s_d.cfg[`BIT_ATACT] = bus.wr_data[`BIT_ATACT];
         s_d.cfg[`BIT_PER_HI:`BIT_PER_LO] = bus.wr_data[`BIT_PER_HI:`BIT_PER_LO];
         // enable is only cleared by the disable code, set by a write of 1
         if (bus.wr_data[`BIT_EN]) begin
            s_d.cfg[`BIT_EN] = 1'b1;
         end
         s_d.cfg[`BIT_ACT] = s_q.cfg[`BIT_ACT] & bus.wr_data[`BIT_ACT];
         s_d.ram_trap = s_q.ram_trap;
      end
      // pending clear of enable: held in a shadow via bit 7
      if (cfg_wr) begin
         s_d.cfg[7] = ~bus.wr_data[`BIT_EN];
      end
      if (cmd_wr) begin
         case (bus.wr_data)
            `CODE_COMMIT: begin
               s_d.ram_trap = s_q.cfg[`BIT_ATRAM];
            end
            `CODE_CLEAR: begin
               s_d.bin = 2'b00;
            end
            `CODE_DISABLE: begin
               if (s_q.cfg[7]) begin
                  s_d.cfg[`BIT_EN] = 1'b0;
                  s_d.pre = '0;
                  s_d.bin = 2'b00;
               end
            end
            default: begin
            end
         endcase
      end
      // interrupts are pulses straight to the core, ignoring imf
      if (ovf && !s_q.cfg[`BIT_ACT]) begin
         s_d.wdt_irq = 1'b1;
      end
      if (trap && !s_q.cfg[`BIT_ATACT]) begin
         s_d.trap_irq = 1'b1;
      end
      // reset pulse, held for at most 24 high clocks
      if (s_q.hold != 5'd0) begin
         s_d.hold = s_q.hold - 5'd1;
         s_d.reset_n = (s_q.hold == 5'd1);
      end else if ((ovf && s_q.cfg[`BIT_ACT]) || (trap && s_q.cfg[`BIT_ATACT])) begin
         s_d.hold = HOLD;
         s_d.reset_n = 1'b0;
      end
   end
   // the block resets itself with the chip when it pulls the pin
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.cfg <= `CFG_RESET;
         s_q.ram_trap <= 1'b1;
         s_q.reset_n <= 1'b1;
      end else if (!s_q.reset_n && s_q.hold == 5'd1) begin
         // last low cycle: the pulled pin resets this block as well
         s_q <= '0;
         s_q.cfg <= `CFG_RESET;
         s_q.ram_trap <= 1'b1;
         s_q.reset_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   assign bus.wdt_irq = s_q.wdt_irq;
   assign bus.trap_irq = s_q.trap_irq;
   assign bus.reset_n = s_q.reset_n;
endmodule

// *** wdt_trap_if.sv ***
// bus between the core and the watchdog block
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface wdt_trap_if;
   logic wr_en;
   logic [15:0] wr_addr;
   logic [7:0] wr_data;
   logic fetch_en;
   logic [15:0] fetch_addr;
   logic interrupt_master_flag;
   logic low_speed;
   logic tap_sel;
   logic low_clk_tick;
   logic wdt_irq;
   logic trap_irq;
   logic reset_n;
   modport dev (
      input wr_en, wr_addr, wr_data, fetch_en, fetch_addr, interrupt_master_flag, low_speed, tap_sel,
      input low_clk_tick,
      output wdt_irq, trap_irq, reset_n
   );
   modport core (
      output wr_en, wr_addr, wr_data, fetch_en, fetch_addr, interrupt_master_flag, low_speed, tap_sel,
      output low_clk_tick,
      input wdt_irq, trap_irq, reset_n
   );
endinterface

// *** wdt_trap_pkg.sv ***
// types used by the core end
// assumes the config header is compiled alongside
package wdt_trap_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_FETCH
   } core_state_type;
endpackage
